// *** hbs_pkg.sv ***
// Overview of operation
// RL1: all bridge enable registers reset to zero
// RL2: configuration register resets to one only
// RL3: command is address byte then data byte
// RL4: only host writes change control bits
// RL5: address bit 7 clear means read only
// RL6: address bit 7 set stores data byte
// RL7: group one address bits six to four 000
// RL8: group two address bits six to four 100
// RL9: group three address bits six to four 010
// RL10: group one pairs low even, high odd
// RL11: group two same pair layout, bridges 5-8
// RL12: group three bridges 9, 10 in D3..D0
// RL13: group three upper nibble reads zero
// RL14: enable bit one switches on, zero off
// RL15: both enables set turns bridge off
// RL16: read leaves stored register contents unchanged
package hbs_pkg;
  localparam int unsigned HBS_FRAME_BITS = 16;
  localparam int unsigned HBS_CNT_W = 4;
  localparam int unsigned HBS_OP_BIT = 7;
  localparam logic [2:0] HBS_SEL_GROUP1 = 3'h0;
  localparam logic [2:0] HBS_SEL_GROUP2 = 3'h4;
  localparam logic [2:0] HBS_SEL_GROUP3 = 3'h2;
  localparam logic [1:0] HBS_ADDR_MID = 2'h0;
  localparam logic [7:0] HBS_GROUP_RESET = 8'h00;
  localparam logic [7:0] HBS_CONFIG_RESET = 8'h01;
  localparam logic [7:0] HBS_GROUP3_MASK = 8'h0f;
  localparam int unsigned HBS_BRIDGES = 10;
  typedef enum logic [2:0] {
    HBS_IDLE = 3'b001,
    HBS_ADDR = 3'b010,
    HBS_DATA = 3'b100
  } hbs_state_t;
endpackage

// *** hbs_bridge_guard.sv ***
module hbs_bridge_guard
  import hbs_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic lower_switch_on, // stored low-side enable
  input wire logic upper_switch_on, // stored high-side enable
  output logic lower_drive, // low-side gate command
  output logic upper_drive // high-side gate command
);
  wire both_on = lower_switch_on & upper_switch_on;

  // registered so a glitch in the decode can never reach a gate
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      lower_drive <= 1'b0;
      upper_drive <= 1'b0;
    end
    else
    begin
      lower_drive <= lower_switch_on & ~both_on; // RL14 RL15
      upper_drive <= upper_switch_on & ~both_on; // RL14 RL15
    end
  end

  a_no_cross_drive: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL15
    !(lower_drive && upper_drive))
    else $error("both switches of one bridge driven");
  a_drive_follows: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL14
    (upper_switch_on && !lower_switch_on) |=> upper_drive)
    else $error("high side not turned on");
endmodule

// *** hbs_switch_regs.sv ***
module hbs_switch_regs
  import hbs_pkg::*;
(
  input wire logic clk_sys, // system clock, 10 MHz
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic spi_csn_pin, // chip select, active low, async pin
  input wire logic spi_sclk_pin, // serial clock pin, async
  input wire logic spi_sdi_pin, // serial data in, msb first
  output logic spi_sdo, // serial data out
  output logic spi_sdo_oe, // high while driving serial out
  output logic [HBS_BRIDGES-1:0] lower_drive, // low-side gate per bridge
  output logic [HBS_BRIDGES-1:0] upper_drive, // high-side gate per bridge
  output logic [7:0] config_value // configuration register contents
);
  logic [1:0] csn_sync;
  logic [1:0] sclk_sync;
  logic [1:0] sdi_sync;
  logic sclk_prev;
  hbs_state_t state;
  hbs_state_t next_state;
  logic [HBS_CNT_W-1:0] bit_cnt;
  logic [7:0] addr_byte;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic [7:0] bridge_switch_enable_group1;
  logic [7:0] bridge_switch_enable_group2;
  logic [7:0] bridge_switch_enable_group3;
  logic [7:0] config_reg;

  // pins are sampled twice before use; only stage one feeds stage two
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      csn_sync <= 2'h3;
      sclk_sync <= 2'h0;
      sdi_sync <= 2'h0;
      sclk_prev <= 1'b0;
    end
    else
    begin
      csn_sync <= {csn_sync[0], spi_csn_pin};
      sclk_sync <= {sclk_sync[0], spi_sclk_pin};
      sdi_sync <= {sdi_sync[0], spi_sdi_pin};
      sclk_prev <= sclk_sync[1];
    end
  end

  wire cs_active = ~csn_sync[1];
  wire sclk_rise = sclk_sync[1] & ~sclk_prev;
  wire sclk_fall = ~sclk_sync[1] & sclk_prev;
  wire last_bit = (bit_cnt == 4'hf);
  wire addr_done = sclk_rise & (bit_cnt == 4'h7);
  wire frame_done = sclk_rise & last_bit & (state == HBS_DATA);
  wire [7:0] data_byte = {shift_in[6:0], sdi_sync[1]};

  // address decode: bit 0 set, bits 3..2 clear, bit 1 is the token
  wire ctrl_form = addr_byte[0] & (addr_byte[3:2] == HBS_ADDR_MID);
  wire [2:0] sel_field = addr_byte[6:4];
  wire hit_g1 = ctrl_form & (sel_field == HBS_SEL_GROUP1); // RL7
  wire hit_g2 = ctrl_form & (sel_field == HBS_SEL_GROUP2); // RL8
  wire hit_g3 = ctrl_form & (sel_field == HBS_SEL_GROUP3); // RL9
  wire is_write = addr_byte[HBS_OP_BIT]; // RL5 RL6
  // only a completed write frame may alter control bits
  wire wr_g1 = frame_done & is_write & hit_g1; // RL4 RL6 RL16
  wire wr_g2 = frame_done & is_write & hit_g2; // RL4 RL6 RL16
  wire wr_g3 = frame_done & is_write & hit_g3; // RL4 RL6 RL16

  // read-back byte chosen from the address byte taken from the sdi bits
  wire [7:0] addr_next = data_byte;
  wire [2:0] sel_next = addr_next[6:4];
  wire form_next = addr_next[0] & (addr_next[3:2] == HBS_ADDR_MID);
  wire [7:0] read_value = !form_next ? 8'h00 :
    (sel_next == HBS_SEL_GROUP1) ? bridge_switch_enable_group1 :
    (sel_next == HBS_SEL_GROUP2) ? bridge_switch_enable_group2 :
    (sel_next == HBS_SEL_GROUP3) ? (bridge_switch_enable_group3 & HBS_GROUP3_MASK) : // RL13
    8'h00;

  always_comb
  begin
    next_state = state;
    case (state)
      HBS_IDLE:
        if (cs_active)
          next_state = HBS_ADDR;
      HBS_ADDR:
        if (!cs_active)
          next_state = HBS_IDLE;
        else if (addr_done)
          next_state = HBS_DATA; // RL3
      HBS_DATA:
        if (!cs_active || frame_done)
          next_state = HBS_IDLE;
      default:
        next_state = HBS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      state <= HBS_IDLE;
    else
      state <= next_state;
  end

  // a frame cut short by chip select is discarded: count restarts
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || state == HBS_IDLE)
      bit_cnt <= '0;
    else if (sclk_rise)
      bit_cnt <= bit_cnt + 4'h1; // RL3
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      shift_in <= 8'h00;
    else if (sclk_rise)
      shift_in <= data_byte;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      addr_byte <= 8'h00;
    else if (addr_done && state == HBS_ADDR)
      addr_byte <= addr_next; // RL3
  end

  // response byte: addressed register during the data byte; the fall that
  // closes the address byte must not shift, or the msb is lost before its rise
  wire first_data_fall = (bit_cnt == 4'h8);
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      shift_out <= 8'h00;
    else if (addr_done && state == HBS_ADDR)
      shift_out <= read_value; // RL5
    else if (sclk_fall && state == HBS_DATA && !first_data_fall)
      shift_out <= {shift_out[6:0], 1'b0};
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      spi_sdo <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end
    else
    begin
      spi_sdo <= shift_out[7];
      spi_sdo_oe <= cs_active;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      bridge_switch_enable_group1 <= HBS_GROUP_RESET; // RL1
      bridge_switch_enable_group2 <= HBS_GROUP_RESET; // RL1
      bridge_switch_enable_group3 <= HBS_GROUP_RESET; // RL1
    end
    else
    begin
      if (wr_g1)
        bridge_switch_enable_group1 <= data_byte;
      if (wr_g2)
        bridge_switch_enable_group2 <= data_byte;
      if (wr_g3)
        bridge_switch_enable_group3 <= data_byte & HBS_GROUP3_MASK; // RL13
    end
  end

  // configuration contents live elsewhere; only its default is held here
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      config_reg <= HBS_CONFIG_RESET; // RL2
    else
      config_reg <= config_reg;
  end
  assign config_value = config_reg;

  // bridge n: low at bit 2(n-1), high one above, across the three groups
  wire [19:0] pairs = {bridge_switch_enable_group3[3:0], bridge_switch_enable_group2,
    bridge_switch_enable_group1}; // RL10 RL11 RL12

  genvar gi;
  generate
    for (gi = 0; gi < HBS_BRIDGES; gi++)
    begin : g_bridge
      hbs_bridge_guard u_guard (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .lower_switch_on(pairs[2*gi]),
        .upper_switch_on(pairs[2*gi+1]),
        .lower_drive(lower_drive[gi]),
        .upper_drive(upper_drive[gi])
      );
    end
  endgenerate

  a_reset_zero: assert property (@(posedge clk_sys) // RL1
    $past(sys_rst) |-> (bridge_switch_enable_group1 == 8'h00 && bridge_switch_enable_group2 == 8'h00))
    else $error("group registers not zero after reset");
  a_config_reset: assert property (@(posedge clk_sys) // RL2
    $past(sys_rst) |-> config_value == 8'h01)
    else $error("configuration default wrong");
  a_g3_upper_zero: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL13
    bridge_switch_enable_group3[7:4] == 4'h0)
    else $error("reserved bits of group three nonzero");
  a_read_keeps: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL16
    (frame_done && !is_write) |=> $stable(bridge_switch_enable_group1) && $stable(bridge_switch_enable_group2))
    else $error("read altered a register");
  a_write_stores: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL6
    wr_g1 |=> bridge_switch_enable_group1 == $past(data_byte))
    else $error("write not stored");
  a_no_self_change: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL4
    !(wr_g1 || wr_g2 || wr_g3) |=> $stable(bridge_switch_enable_group1) && $stable(bridge_switch_enable_group2)
      && $stable(bridge_switch_enable_group3))
    else $error("control bits changed without a write");
  a_g2_decode: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL8
    wr_g2 |-> addr_byte[6:4] == 3'h4 && addr_byte[7])
    else $error("group two written by wrong address");
  a_frame_length: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL3
    frame_done |-> bit_cnt == 4'hf)
    else $error("frame not sixteen bits");
  c_write_g1: cover property (@(posedge clk_sys) disable iff (sys_rst) wr_g1);
  c_write_g3: cover property (@(posedge clk_sys) disable iff (sys_rst) wr_g3);
  c_read_frame: cover property (@(posedge clk_sys) disable iff (sys_rst) frame_done && !is_write);
  c_cross_block: cover property (@(posedge clk_sys) disable iff (sys_rst) pairs[1:0] == 2'h3);
endmodule

// *** hbs_spi_host.sv ***
module hbs_spi_host (
  input wire logic clk_sys, // system clock
  output logic cs_n, // chip select, active low
  output logic sclk, // serial clock, idles low
  output logic sdi, // serial data to device
  input wire logic sdo // serial data from device
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // nb below 16 aborts the frame early; half periods of 6 clocks keep clear of the sync delay
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input int nb, output logic [7:0] q);
    logic [15:0] w;
    w = {a, d};
    q = 8'h00;
    cs_n = 1'b0;
    wt(6);
    for (int i = 15; i >= 16 - nb; i--)
    begin
      sdi = w[i];
      wt(6);
      if (i < 8)
        q[i] = sdo;
      sclk = 1'b1;
      wt(6);
      sclk = 1'b0;
    end
    wt(6);
    cs_n = 1'b1;
    // released line: show the inverse so a stale value is never mistaken for data
    sdi = ~sdi;
    wt(8);
  endtask
endmodule

// *** hbs_switch_regs_bench.sv ***
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin fail_count++; $display("MISMATCH %0t %s", $time, m); end end
module hbs_switch_regs_bench import hbs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  wire cs_n, sclk, sdi, sdo, sdo_oe;
  wire [HBS_BRIDGES-1:0] lo, hi;
  wire [7:0] cfg;
  int fail_count = 0;
  int n_checks = 0;
  int g[3] = '{0, 0, 0};
  logic [15:0] lf = 16'd37911;
  logic [7:0] q;
  logic [7:0] ad[3] = '{8'h01, 8'h41, 8'h21};
  always #50 clk_sys = ~clk_sys;
  hbs_spi_host host (.clk_sys(clk_sys), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));
  hbs_switch_regs uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .spi_csn_pin(cs_n), .spi_sclk_pin(sclk),
    .spi_sdi_pin(sdi), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .lower_drive(lo), .upper_drive(hi),
    .config_value(cfg));
  function automatic logic [7:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf[7:0];
  endfunction
  task automatic drives();
    logic [19:0] c;
    c = {g[2][3:0], g[1][7:0], g[0][7:0]};
    for (int n = 0; n < HBS_BRIDGES; n++)
    begin
      `CHK(lo[n], c[2*n] & ~c[2*n+1], "low drive")
      `CHK(hi[n], c[2*n+1] & ~c[2*n], "high drive")
    end
  endtask
  task automatic wr(input int k, input logic [7:0] d);
    host.xfer(ad[k] | 8'h80, d, 16, q);
    g[k] = (k == 2) ? (d & 8'h0f) : d;
    drives();
  endtask
  task automatic rd(input int k);
    host.xfer(ad[k], rnd(), 16, q);
    `CHK(q, g[k][7:0], "read back")
    `CHK(sdo_oe, 1'b0, "sdo driven after frame")
  endtask
  task automatic close_out();
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(negedge clk_sys);
    sys_rst = 1'b0;
    host.wt(4);
    `CHK(cfg, HBS_CONFIG_RESET, "config reset")
    drives();
    for (int k = 0; k < 3; k++)
      rd(k);
    for (int r = 0; r < 4; r++)
      for (int k = 0; k < 3; k++)
      begin
        wr(k, rnd());
        rd(k);
        rd(k);
      end
    wr(0, 8'hff);
    wr(2, 8'hfa);
    rd(2);
    // token bit set must still hit the register
    host.xfer(8'h83, 8'h01, 16, q);
    g[0] = 1;
    drives();
    host.xfer(8'h81, 8'h55, 8, q);
    drives();
    host.xfer(8'he1, 8'h55, 16, q);
    host.xfer(8'h85, 8'h55, 16, q);
    drives();
    rd(0);
    sys_rst = 1'b1;
    host.wt(4);
    sys_rst = 1'b0;
    host.wt(4);
    g = '{0, 0, 0};
    drives();
    `CHK(cfg, HBS_CONFIG_RESET, "config after reset")
    rd(1);
    close_out();
  end
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    fail_count++;
    close_out();
  end
endmodule
